/* shared/fsl_pkg.sv */
package fsl_pkg;
  localparam logic [6:0]  FSL_FAULT_STATUS_TWO_ADDR = 7'h32;
  localparam int          FSL_STATUS_WIDTH          = 24;
  localparam logic [23:0] FSL_STATUS_RESET          = 24'h00_0000;
  localparam int FSL_BIT_LIN_BUS_STUCK_DOM   = 23;
  localparam int FSL_BIT_LIN_TX_STUCK_DOM    = 22;
  localparam int FSL_BIT_LIN_BUS_NOT_FOLLOW  = 21;
  localparam int FSL_BIT_CAN_RX_NOT_FOLLOW   = 20;
  localparam int FSL_BIT_CAN_BUS_NOT_FOLLOW  = 19;
  localparam int FSL_BIT_CAN_BUS_STUCK_DOM   = 18;
  localparam int FSL_BIT_CAN_TX_STUCK_DOM    = 17;
  localparam int FSL_BIT_CAN_SUPPLY_LOW      = 16;
  localparam int FSL_BIT_DSMON_LO            = 12;
  localparam int FSL_BIT_SERIAL_INVALID      = 11;
  localparam int FSL_BIT_SERIAL_CLK_COUNT    = 10;
  localparam int FSL_BIT_CHARGE_PUMP_LOW     = 9;
  localparam int FSL_BIT_THERMAL_WARNING     = 8;
  localparam int FSL_BIT_SECOND_REG_SHORT    = 7;
  localparam int FSL_BIT_SECOND_REG_FAIL     = 6;
  localparam int FSL_BIT_FIRST_REG_FAIL      = 5;
  localparam int FSL_BIT_REG_SUPPLY_EW       = 4;
  localparam int FSL_BIT_SUPPLY_LO           = 0;
  localparam int FSL_CAN_MISS_LIMIT          = 4;
  localparam int FSL_CLUSTER_COUNT           = 8;
  // Read-only self-clearing bit; excluded from read-and-clear.
  localparam logic [23:0] FSL_CLEAR_MASK     = 24'hFF_FBFF;
endpackage

/* shared/fsl_cnt_if.sv */
`timescale 1ns/100ps
interface fsl_cnt_if;
  logic miss;
  logic clear;
  logic hit;
  modport owner (input miss, input clear, output hit);
  modport user  (output miss, output clear, input hit);
endinterface

/* core/fsl_miss_counter.sv */
`timescale 1ns/100ps
module fsl_miss_counter (
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  fsl_cnt_if.owner   cnt
);
  logic [2:0] count;

  // Counts mismatch events and saturates at the limit. The hit is held until the clear.
  always_ff @(posedge mclk) begin
    if (sys_rst || cnt.clear) begin
      count <= 3'h0;
    end else if (cnt.miss && count != 3'(fsl_pkg::FSL_CAN_MISS_LIMIT)) begin
      count <= count + 3'h1;
    end
  end

  // The hit is masked while the clear is applied, so a saturated count cannot
  // set the latched flag again in the very cycle in which both are cleared.
  assign cnt.hit = (count == 3'(fsl_pkg::FSL_CAN_MISS_LIMIT)) && !cnt.clear;
endmodule // fsl_miss_counter

/* core/fault_status_latch_bank.sv */
`timescale 1ns/100ps
// Operation
// [RULE1] Read-and-clear flags stay set until the host read-and-clears the register.
// [RULE2] Bit 23 sets when the LIN bus stays dominant past timeout.
// [RULE3] Bit 22 sets on LIN transmit stuck dominant; LIN transmitter disabled meanwhile.
// [RULE4] Bit 21 sets when LIN bus fails to follow; LIN transmitter disabled.
// [RULE5] Bit 20 sets after four CAN receive mismatches; CAN transmitter disabled.
// [RULE6] Bit 19 sets after four CAN bus mismatches; CAN transmitter disabled.
// [RULE7] Bit 18 sets when the CAN bus stays dominant past timeout.
// [RULE8] Bit 17 sets on CAN transmit stuck dominant; CAN transmitter disabled.
// [RULE9] Bit 16 sets when the CAN transceiver supply is low.
// [RULE10] Bits 15 to 12 latch the four drain-source monitor faults.
// [RULE11] Bit 11 sets on any serial frame fault. The code does not set it on a wrong clock count, which sets bit 10 only.
// [RULE12] A frame with an invalid command is discarded entirely.
// [RULE13] Read-only bit 10 flags wrong clock count, clears on next good frame.
// [RULE14] Bit 9 sets when charge pump voltage is low.
// [RULE15] Bit 8 latches the OR of all cluster thermal warnings.
// [RULE16] Bit 7 sets on second regulator short at turn-on.
// [RULE17] Bit 6 sets on second regulator fail past the filter time.
// [RULE18] Bit 5 sets on first regulator fail past the filter time.
// [RULE19] Bit 4 sets on supply early warning; pulse interrupt in active mode.
// [RULE20] Host read-and-clears the early warning after wake from standby.
// [RULE21] Bits 3 to 0 latch supply over and undervoltage flags.
// [RULE22] Read-and-clear returns pre-clear value; persisting faults set again.
module fault_status_latch_bank (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Filtered fault detections from the analog and transceiver monitors.
  input  wire logic        lin_bus_stuck_dominant,
  input  wire logic        lin_tx_stuck_dominant,
  input  wire logic        lin_bus_not_following_tx,
  input  wire logic        can_rx_mismatch,
  input  wire logic        can_bus_mismatch,
  input  wire logic        can_bus_stuck_dominant,
  input  wire logic        can_tx_stuck_dominant,
  input  wire logic        can_supply_low_warning,
  input  wire logic        drain_source_mon_high_b,
  input  wire logic        drain_source_mon_high_a,
  input  wire logic        drain_source_mon_low_b,
  input  wire logic        drain_source_mon_low_a,
  input  wire logic        charge_pump_low,
  input  wire logic [7:0]  cluster_thermal_warning,
  input  wire logic        second_regulator_short,
  input  wire logic        second_regulator_fail,
  input  wire logic        first_regulator_fail,
  input  wire logic        regulator_supply_early_warning,
  input  wire logic        regulator_supply_overvoltage,
  input  wire logic        regulator_supply_undervoltage,
  input  wire logic        battery_overvoltage,
  input  wire logic        battery_undervoltage,
  input  wire logic        active_mode,
  // Decoded serial frame from the control interface, one-cycle strobe at frame end.
  input  wire logic        frame_done,
  input  wire logic [6:0]  frame_addr,
  input  wire logic        frame_read_clear,
  input  wire logic        frame_write,
  input  wire logic        frame_clock_count_bad,
  input  wire logic        frame_parity_bad,
  input  wire logic        frame_data_stuck,
  input  wire logic        frame_select_timeout,
  input  wire logic        frame_addr_undefined,
  input  wire logic        frame_setting_invalid,
  output logic [23:0]      read_data,
  output logic             read_valid,
  output logic             lin_tx_enable,
  output logic             can_tx_enable,
  output logic             interrupt_output_low_active
);
  //////////////////////////////////////////////////////////////////////////////
  logic [23:0] status;
  logic [23:0] next_status;
  logic        ew_prev;

  fsl_cnt_if rx_cnt ();
  fsl_cnt_if bus_cnt ();

  wire hit_this_reg    = (frame_addr == fsl_pkg::FSL_FAULT_STATUS_TWO_ADDR);
  wire write_to_status = frame_write && hit_this_reg;
  // [RULE11] frame fault collection
  wire frame_invalid   = frame_parity_bad || frame_data_stuck || frame_select_timeout ||
                         frame_addr_undefined || frame_setting_invalid || write_to_status;
  wire frame_counted_ok = frame_done && !frame_clock_count_bad;
  // [RULE12] invalid frames dropped
  wire frame_good      = frame_counted_ok && !frame_invalid;
  wire do_read_clear   = frame_good && frame_read_clear && hit_this_reg;
  wire do_read         = frame_good && !frame_write && hit_this_reg;
  // [RULE15] OR of cluster warnings
  wire thermal_any     = |cluster_thermal_warning;
  wire ew_rise         = regulator_supply_early_warning && !ew_prev;

  //////////////////////////////////////////////////////////////////////////////
  // [RULE5] receive mismatch counter
  assign rx_cnt.miss   = can_rx_mismatch;
  assign rx_cnt.clear  = do_read_clear;
  // [RULE6] bus mismatch counter
  assign bus_cnt.miss  = can_bus_mismatch;
  assign bus_cnt.clear = do_read_clear;

  fsl_miss_counter u_rx_cnt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .cnt     (rx_cnt)
  );

  fsl_miss_counter u_bus_cnt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .cnt     (bus_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  logic [23:0] set_vec;
  always_comb begin
    set_vec = 24'h00_0000;
    // [RULE2] LIN bus dominant
    set_vec[fsl_pkg::FSL_BIT_LIN_BUS_STUCK_DOM]  = lin_bus_stuck_dominant;
    // [RULE3] LIN transmit dominant
    set_vec[fsl_pkg::FSL_BIT_LIN_TX_STUCK_DOM]   = lin_tx_stuck_dominant;
    // [RULE4] LIN not following
    set_vec[fsl_pkg::FSL_BIT_LIN_BUS_NOT_FOLLOW] = lin_bus_not_following_tx;
    set_vec[fsl_pkg::FSL_BIT_CAN_RX_NOT_FOLLOW]  = rx_cnt.hit;
    set_vec[fsl_pkg::FSL_BIT_CAN_BUS_NOT_FOLLOW] = bus_cnt.hit;
    // [RULE7] CAN bus dominant
    set_vec[fsl_pkg::FSL_BIT_CAN_BUS_STUCK_DOM]  = can_bus_stuck_dominant;
    // [RULE8] CAN transmit dominant
    set_vec[fsl_pkg::FSL_BIT_CAN_TX_STUCK_DOM]   = can_tx_stuck_dominant;
    // [RULE9] CAN supply low
    set_vec[fsl_pkg::FSL_BIT_CAN_SUPPLY_LOW]     = can_supply_low_warning;
    // [RULE10] drain-source monitors
    set_vec[fsl_pkg::FSL_BIT_DSMON_LO +: 4]      = {drain_source_mon_high_b,
                                                    drain_source_mon_high_a,
                                                    drain_source_mon_low_b,
                                                    drain_source_mon_low_a};
    set_vec[fsl_pkg::FSL_BIT_SERIAL_INVALID]     = frame_counted_ok && frame_invalid;
    // [RULE14] charge pump low
    set_vec[fsl_pkg::FSL_BIT_CHARGE_PUMP_LOW]    = charge_pump_low;
    set_vec[fsl_pkg::FSL_BIT_THERMAL_WARNING]    = thermal_any;
    // [RULE16] regulator short
    set_vec[fsl_pkg::FSL_BIT_SECOND_REG_SHORT]   = second_regulator_short;
    // [RULE17] second regulator fail
    set_vec[fsl_pkg::FSL_BIT_SECOND_REG_FAIL]    = second_regulator_fail;
    // [RULE18] first regulator fail
    set_vec[fsl_pkg::FSL_BIT_FIRST_REG_FAIL]     = first_regulator_fail;
    // [RULE19] early warning flag
    set_vec[fsl_pkg::FSL_BIT_REG_SUPPLY_EW]      = regulator_supply_early_warning;
    // [RULE21] supply flags
    set_vec[fsl_pkg::FSL_BIT_SUPPLY_LO +: 4]     = {regulator_supply_overvoltage,
                                                    regulator_supply_undervoltage,
                                                    battery_overvoltage,
                                                    battery_undervoltage};
  end

  // The clock-count bit follows its own set/clear; it is never read-cleared.
  always_comb begin
    // [RULE1] sticky until read-and-clear; [RULE22] set wins over clear
    next_status = (do_read_clear ? (status & ~fsl_pkg::FSL_CLEAR_MASK) : status) | set_vec;
    // [RULE13] clock count self-clear
    if (frame_done && frame_clock_count_bad) begin
      next_status[fsl_pkg::FSL_BIT_SERIAL_CLK_COUNT] = 1'b1;
    end else if (frame_good) begin
      next_status[fsl_pkg::FSL_BIT_SERIAL_CLK_COUNT] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status <= fsl_pkg::FSL_STATUS_RESET;
      ew_prev <= 1'b0;
    end else begin
      status <= next_status;
      ew_prev <= regulator_supply_early_warning;
    end
  end

  // [RULE22] pre-clear value returned
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      read_data  <= 24'h00_0000;
      read_valid <= 1'b0;
    end else begin
      read_valid <= do_read;
      if (do_read) begin
        read_data <= status;
      end
    end
  end

  // Transmitters stay off while any of their blocking faults is latched.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lin_tx_enable <= 1'b1;
      can_tx_enable <= 1'b1;
      interrupt_output_low_active <= 1'b1;
    end else begin
      // [RULE3] [RULE4] LIN transmitter block
      lin_tx_enable <= !(next_status[fsl_pkg::FSL_BIT_LIN_TX_STUCK_DOM] ||
                         next_status[fsl_pkg::FSL_BIT_LIN_BUS_NOT_FOLLOW]);
      // [RULE5] [RULE6] [RULE8] CAN transmitter block
      can_tx_enable <= !(next_status[fsl_pkg::FSL_BIT_CAN_RX_NOT_FOLLOW] ||
                         next_status[fsl_pkg::FSL_BIT_CAN_BUS_NOT_FOLLOW] ||
                         next_status[fsl_pkg::FSL_BIT_CAN_TX_STUCK_DOM]);
      // [RULE19] active-mode interrupt pulse
      interrupt_output_low_active <= !(ew_rise && active_mode);
    end
  end
endmodule // fault_status_latch_bank

/* testbench/fsl_chk.sv */
`timescale 1ns/100ps
module fsl_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        lin_bus_stuck_dominant,
  input wire logic        lin_tx_stuck_dominant,
  input wire logic        can_tx_stuck_dominant,
  input wire logic        battery_undervoltage,
  input wire logic        regulator_supply_early_warning,
  input wire logic        active_mode,
  input wire logic        frame_done,
  input wire logic [6:0]  frame_addr,
  input wire logic        frame_write,
  input wire logic        frame_clock_count_bad,
  input wire logic [23:0] read_data,
  input wire logic        read_valid,
  input wire logic        lin_tx_enable,
  input wire logic        can_tx_enable,
  input wire logic        interrupt_output_low_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire rd_hit = frame_done && frame_addr == fsl_pkg::FSL_FAULT_STATUS_TWO_ADDR && !frame_write;
  a_lin_tx_block : assert property (lin_tx_stuck_dominant |=> !lin_tx_enable)
    else $error("lin transmitter not blocked");
  a_can_tx_block : assert property (can_tx_stuck_dominant |=> !can_tx_enable)
    else $error("can transmitter not blocked");
  a_read_cause : assert property (read_valid |-> $past(rd_hit))
    else $error("read answer without read frame");
  a_lin_dom_seen : assert property (
    read_valid && $past(lin_bus_stuck_dominant, 2) |-> read_data[23])
    else $error("bus dominant flag missing");
  a_supply_seen : assert property (
    read_valid && $past(battery_undervoltage, 2) |-> read_data[0])
    else $error("undervoltage flag missing");
  a_irq_pulse : assert property (
    active_mode && $rose(regulator_supply_early_warning) |=> !interrupt_output_low_active)
    else $error("no interrupt pulse");
  a_irq_one_cycle : assert property (
    !interrupt_output_low_active |=> interrupt_output_low_active)
    else $error("interrupt pulse too long");
  a_bad_count_quiet : assert property (
    frame_done && frame_clock_count_bad |=> !read_valid)
    else $error("bad clock count frame answered");
endmodule // fsl_chk

/* testbench/fsl_host.sv */
`timescale 1ns/100ps
module fsl_host (
  input wire logic        mclk,
  input wire logic        read_valid,
  input wire logic [23:0] read_data,
  output logic            frame_done,
  output logic [6:0]      frame_addr,
  output logic            frame_read_clear,
  output logic            frame_write,
  output logic [5:0]      err
);
  initial {frame_done, frame_addr, frame_read_clear, frame_write, err} = 16'h0000;
  // Between frames the lines carry the inverse, so a stale value is never mistaken for data.
  task automatic send(input logic [6:0] a, input logic rc, input logic wr, input logic [5:0] e,
                      output logic [23:0] d, output logic v);
    @(posedge mclk);
    {frame_done, frame_addr, frame_read_clear, frame_write, err} <= {1'b1, a, rc, wr, e};
    @(posedge mclk);
    {frame_done, frame_addr, frame_read_clear, frame_write, err} <= {1'b0, ~a, ~rc, ~wr, ~e};
    @(negedge mclk);
    v = read_valid;
    d = read_data;
  endtask
endmodule // fsl_host

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [23:0] flt = 24'h00_0000;
  logic        act = 1'b1;
  logic        done, rc, wr, rv, lin_en, can_en, irq_n;
  logic [6:0]  addr;
  logic [5:0]  err;
  logic [23:0] rdat;
  int          miscompares = 0;
  int          tests_run = 0;
  always #5 mclk = ~mclk;
  fault_status_latch_bank fault_status_latch_bank_i (.mclk(mclk), .sys_rst(sys_rst),
    .lin_bus_stuck_dominant(flt[23]), .lin_tx_stuck_dominant(flt[22]),
    .lin_bus_not_following_tx(flt[21]), .can_rx_mismatch(flt[20]), .can_bus_mismatch(flt[19]),
    .can_bus_stuck_dominant(flt[18]), .can_tx_stuck_dominant(flt[17]),
    .can_supply_low_warning(flt[16]), .drain_source_mon_high_b(flt[15]),
    .drain_source_mon_high_a(flt[14]), .drain_source_mon_low_b(flt[13]),
    .drain_source_mon_low_a(flt[12]), .charge_pump_low(flt[9]),
    .cluster_thermal_warning({flt[8], 7'h00}), .second_regulator_short(flt[7]),
    .second_regulator_fail(flt[6]), .first_regulator_fail(flt[5]),
    .regulator_supply_early_warning(flt[4]), .regulator_supply_overvoltage(flt[3]),
    .regulator_supply_undervoltage(flt[2]), .battery_overvoltage(flt[1]),
    .battery_undervoltage(flt[0]), .active_mode(act), .frame_done(done), .frame_addr(addr),
    .frame_read_clear(rc), .frame_write(wr), .frame_clock_count_bad(err[0]),
    .frame_parity_bad(err[1]), .frame_data_stuck(err[2]), .frame_select_timeout(err[3]),
    .frame_addr_undefined(err[4]), .frame_setting_invalid(err[5]), .read_data(rdat),
    .read_valid(rv), .lin_tx_enable(lin_en), .can_tx_enable(can_en),
    .interrupt_output_low_active(irq_n));
  fsl_host fsl_host_i (.mclk(mclk), .read_valid(rv), .read_data(rdat), .frame_done(done),
    .frame_addr(addr), .frame_read_clear(rc), .frame_write(wr), .err(err));
  task automatic cmp24(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic send(input logic c, input logic w, input logic [5:0] e, input logic [23:0] x,
                      input logic xv);
    logic [23:0] d;
    logic        v;
    fsl_host_i.send(fsl_pkg::FSL_FAULT_STATUS_TWO_ADDR, c, w, e, d, v);
    cmp24({23'h00_0000, v}, {23'h00_0000, xv});
    if (xv) cmp24(d, x);
  endtask
  task automatic pulse(input int b);
    @(posedge mclk) flt[b] <= 1'b1;
    @(posedge mclk) flt[b] <= 1'b0;
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    send(1'b0, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    for (int b = 0; b < 24; b++) begin
      if (b inside {10, 11, 19, 20}) continue;
      pulse(b);
      @(negedge mclk);
      cmp24({23'h00_0000, irq_n}, {23'h00_0000, b != 4});
      @(negedge mclk);
      // Transmitter blocking follows the latched fault bits.
      cmp24({23'h00_0000, lin_en}, {23'h00_0000, !(b inside {21, 22})});
      cmp24({23'h00_0000, can_en}, {23'h00_0000, b != 17});
      send(1'b1, 1'b0, 6'h00, 24'h00_0001 << b, 1'b1);
      cmp24({22'h00_0000, lin_en, can_en}, 24'h00_0003);
      send(1'b1, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    end
    for (int b = 19; b < 21; b++) begin
      repeat (3) pulse(b);
      send(1'b0, 1'b0, 6'h00, 24'h00_0000, 1'b1);
      pulse(b);
      repeat (2) @(negedge mclk);
      cmp24({23'h00_0000, can_en}, 24'h00_0000);
      send(1'b1, 1'b0, 6'h00, 24'h00_0001 << b, 1'b1);
      cmp24({23'h00_0000, can_en}, 24'h00_0001);
      send(1'b1, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    end
    for (int k = 1; k < 7; k++) begin
      pulse(0);
      send(1'b1, k == 6, (k < 6) ? 6'h01 << k : 6'h00, 24'h00_0000, 1'b0);
      send(1'b1, 1'b0, 6'h00, 24'h00_0801, 1'b1);
    end
    send(1'b1, 1'b0, 6'h01, 24'h00_0000, 1'b0);
    send(1'b1, 1'b0, 6'h00, 24'h00_0400, 1'b1);
    send(1'b1, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    // Standby: the warning latches without a pulse; the host clears it after wake.
    @(posedge mclk) act <= 1'b0;
    pulse(4);
    @(negedge mclk);
    cmp24({23'h00_0000, irq_n}, 24'h00_0001);
    @(posedge mclk) act <= 1'b1;
    send(1'b1, 1'b0, 6'h00, 24'h00_0010, 1'b1);
    send(1'b1, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    @(posedge mclk) {flt[23], flt[0]} <= 2'b11;
    send(1'b1, 1'b0, 6'h00, 24'h80_0001, 1'b1);
    @(posedge mclk) {flt[23], flt[0]} <= 2'b00;
    send(1'b1, 1'b0, 6'h00, 24'h80_0001, 1'b1);
    send(1'b1, 1'b0, 6'h00, 24'h00_0000, 1'b1);
    end_of_test();
  end
endmodule // tb_top
bind fault_status_latch_bank fsl_chk fsl_chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .lin_bus_stuck_dominant(lin_bus_stuck_dominant), .lin_tx_stuck_dominant(lin_tx_stuck_dominant),
  .can_tx_stuck_dominant(can_tx_stuck_dominant), .battery_undervoltage(battery_undervoltage),
  .regulator_supply_early_warning(regulator_supply_early_warning), .active_mode(active_mode),
  .frame_done(frame_done), .frame_addr(frame_addr), .frame_write(frame_write),
  .frame_clock_count_bad(frame_clock_count_bad), .read_data(read_data), .read_valid(read_valid),
  .lin_tx_enable(lin_tx_enable), .can_tx_enable(can_tx_enable),
  .interrupt_output_low_active(interrupt_output_low_active));
